//--- logic/sdl_device.sv
// converter end: serial shift, input register, output latch, switches
`timescale 1ns/1ps
`include "sdl_map.svh"
// Operation
// - every word and data register is 16 bits
// - power-up clears input register and output latch
// - shift register keeps no reset value
// - short frame keeps leftover shift bits
// - master's first frame carries sixteen bits
// - master pads short data with low zeros
// - chip select high ignores clock and data
// - master lowers select, changes data on falls
// - sample data on rising clock, MSB first
// - select rising copies shift into input register
// - master sends sixteen clocks, then raises select
// - long frame keeps only last sixteen bits
// - short frame is corrupt, master resends word
// - no-load variant latches with input register
// - load strobe low after select updates latch
// - master holds load strobe high during frame
// - strobe tied low latches right after load
// - latch code is unsigned, output code/65536
// - upper nibble to segments, twelve bits ladder
// - master waits ten microseconds after power-up
module sdl_device #(
  parameter bit HAS_LOAD = 1'b1            // variant with load strobe pin
) (
  input wire logic i_mclk,                 // system clock
  input wire logic i_resetn,               // power-on reset, active low
  sdl_link_if.device lnk,                  // link from the master
  output sdl_pkg::sdl_word_t o_input_word, // input register
  output sdl_pkg::sdl_word_t o_latch_word, // output latch, unsigned code
  output sdl_pkg::sdl_seg_t o_segment_switch_ctl, // segment switches
  output sdl_pkg::sdl_ladder_t o_ladder_switch_ctl, // ladder switches
  output logic o_word_loaded,              // pulse: input register loaded
  output logic o_latch_updated,            // pulse: output latch changed
  output logic o_short_word,               // last frame had < 16 clocks
  output logic o_long_word,                // last frame had > 16 clocks
  output sdl_pkg::sdl_cnt_t o_frame_bits   // clocks seen, saturating
);
  import sdl_pkg::*;

  // ---------------- link clock domain ----------------

  sdl_word_t shift_q;
  sdl_cnt_t bits_q;
  logic first_q;

  // no reset here: contents are undefined until bits arrive
  // shifting only while selected old bits stay
  // a long frame pushes early bits out the top
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.cs_n) begin
      shift_q <= {shift_q[`SDL_WORD_W-2:0], lnk.sdi};
    end
  end

  // marks the first clock of a frame; set while deselected
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // clocks per frame, saturating; frozen between frames since the
  // link clock stands still then, so the system side may read it
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.cs_n) begin
      if (first_q) begin
        bits_q <= 5'h01;
      end else if (bits_q != 5'h1F) begin
        bits_q <= bits_q + 5'h01;
      end
    end
  end

  // ---------------- system clock domain ----------------

  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ld_s1_q, ld_s2_q;
  logic cs_rise;
  logic ld_active;

  // chip select synchroniser, idle high; third stage for edge only
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= lnk.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // load strobe synchroniser, idle high
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
    end else begin
      ld_s1_q <= lnk.latch_load_n;
      ld_s2_q <= ld_s1_q;
    end
  end

  // end of frame seen after synchronising; the shift register and
  // bit count are quiet by then, so a plain copy is safe
  assign cs_rise = cs_s2_q && !cs_s3_q;

  // strobe counts only while deselected
  assign ld_active = HAS_LOAD && !ld_s2_q && cs_s2_q;

  sdl_word_t input_q;
  sdl_word_t latch_q;
  sdl_word_t latch_d;
  logic latch_we;

  // input register: zero at power-up, then each frame end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      input_q <= `SDL_RST_WORD;
    end else if (cs_rise) begin
      input_q <= shift_q;
    end
  end

  // next latch value: with the word itself on the no-load variant,
  // else from the input register while the strobe is low
  always_comb begin
    latch_we = 1'b0;
    latch_d = latch_q;
    if (!HAS_LOAD) begin
      if (cs_rise) begin
        latch_we = 1'b1;
        latch_d = shift_q;
      end
    end else if (ld_active) begin
      // tied low: follows one clock after the load
      latch_we = 1'b1;
      latch_d = input_q;
    end
  end

  // output latch holds zero code from power-up
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_q <= `SDL_RST_WORD;
    end else begin
      latch_q <= latch_d;
    end
  end

  sdl_seg_t seg_d;
  sdl_seg_t seg_q;
  sdl_ladder_t ladder_q;

  // decode from the next latch value so switches line up with it
  sdl_seg_decode u_seg (
    .i_nibble (latch_d[`SDL_WORD_W-1:`SDL_LADDER_W]),
    .o_seg    (seg_d)
  );

  // switch controls registered together with the latch
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      seg_q <= '0;
      ladder_q <= '0;
    end else begin
      seg_q <= seg_d;
      ladder_q <= latch_d[`SDL_LADDER_W-1:0];
    end
  end

  logic loaded_q, updated_q;

  // event pulses, one system clock each
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      loaded_q <= 1'b0;
      updated_q <= 1'b0;
    end else begin
      loaded_q <= cs_rise;
      updated_q <= latch_we && (latch_d != latch_q);
    end
  end

  logic short_q, long_q;
  sdl_cnt_t fbits_q;

  // frame length check; a short word is still loaded, since the
  // converter cannot tell padding from intent, but it is flagged
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      short_q <= 1'b0;
      long_q <= 1'b0;
      fbits_q <= '0;
    end else if (cs_rise) begin
      fbits_q <= bits_q;
      short_q <= (bits_q < 5'(`SDL_WORD_W));
      long_q <= (bits_q > 5'(`SDL_WORD_W));
    end
  end

  assign o_input_word = input_q;
  assign o_latch_word = latch_q;
  assign o_segment_switch_ctl = seg_q;
  assign o_ladder_switch_ctl = ladder_q;
  assign o_word_loaded = loaded_q;
  assign o_latch_updated = updated_q;
  assign o_short_word = short_q;
  assign o_long_word = long_q;
  assign o_frame_bits = fbits_q;
endmodule

//--- shared/sdl_map.svh
// constants for the serial word loader: widths, reset values, timing
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

`define SDL_WORD_W 16
`define SDL_NIB_W 4
`define SDL_SEG_N 15
`define SDL_LADDER_W 12
`define SDL_RST_WORD 16'h0000
`define SDL_CNT_W 5

// system clock rate in kHz
`define SDL_MCLK_KHZ 10000

// supply-up to first frame, least time, in microseconds
`define SDL_PWRUP_US 10
`define SDL_PWRUP_CYC (((`SDL_PWRUP_US * `SDL_MCLK_KHZ) + 999) / 1000)

// chip select high to load strobe low, least time, in ns
`define SDL_DLDAC_NS 30
`define SDL_DLDAC_CYC (((`SDL_DLDAC_NS * `SDL_MCLK_KHZ) + 999999) / 1000000)

// load strobe width, least time, in ns
`define SDL_WLDAC_NS 30
`define SDL_WLDAC_CYC (((`SDL_WLDAC_NS * `SDL_MCLK_KHZ) + 999999) / 1000000)

// chip select high between frames, least time, in ns
`define SDL_TD_NS 30
`define SDL_TD_CYC (((`SDL_TD_NS * `SDL_MCLK_KHZ) + 999999) / 1000000)

// device-side edge detect needs chip select high this many clocks
`define SDL_SYNC_CYC 3

`endif

//--- shared/sdl_pkg.sv
// types shared by both ends of the serial word loader
package sdl_pkg;
  typedef logic [15:0] sdl_word_t;
  typedef logic [14:0] sdl_seg_t;
  typedef logic [11:0] sdl_ladder_t;
  typedef logic [4:0] sdl_cnt_t;

  typedef enum logic [6:0] {
    SDL_ST_PWR  = 7'h01,
    SDL_ST_IDLE = 7'h02,
    SDL_ST_LO   = 7'h04,
    SDL_ST_HI   = 7'h08,
    SDL_ST_TAIL = 7'h10,
    SDL_ST_GAP  = 7'h20,
    SDL_ST_LOAD = 7'h40
  } sdl_mst_state_t;
endpackage

//--- shared/sdl_link_if.sv
// three-wire link plus load strobe between master and converter
`timescale 1ns/1ps
interface sdl_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic latch_load_n;

  modport device (
    input cs_n,
    input sclk,
    input sdi,
    input latch_load_n
  );

  modport master (
    output cs_n,
    output sclk,
    output sdi,
    output latch_load_n
  );
endinterface

//--- logic/sdl_seg_decode.sv
// thermometer decode of the upper nibble into segment controls
`timescale 1ns/1ps
`include "sdl_map.svh"
module sdl_seg_decode (
  input wire logic [3:0] i_nibble,       // upper four code bits
  output sdl_pkg::sdl_seg_t o_seg        // bit k set when nibble > k
);
  import sdl_pkg::*;

  // segment k is on once the nibble reaches k+1
  for (genvar k = 0; k < `SDL_SEG_N; k++) begin : g_seg
    assign o_seg[k] = (i_nibble >= 4'(k + 1));
  end
endmodule

//--- logic/sdl_master.sv
// master end: power-up wait, frame generation, load strobe
`timescale 1ns/1ps
`include "sdl_map.svh"
module sdl_master #(
  parameter int HALF_CYC = 2,               // clocks per link half period
  parameter int GAP_CYC = 4,                // select-high clocks per frame
  parameter int LOAD_CYC = 3,               // load strobe width in clocks
  parameter bit LOAD_TIED = 1'b0,           // hold load strobe low after power-up wait
  parameter int PWRUP_CYC = `SDL_PWRUP_CYC  // power-up wait in clocks
) (
  input wire logic i_mclk,                  // system clock
  input wire logic i_resetn,                // async reset, active low
  input wire logic i_start,                 // request: send i_word
  input wire sdl_pkg::sdl_word_t i_word,    // data, MSB aligned
  input wire sdl_pkg::sdl_cnt_t i_len,      // valid bits, 0 means 16
  output logic o_busy,                      // frame or wait in progress
  output logic o_done,                      // pulse: frame finished
  sdl_link_if.master lnk                    // link to the converter
);
  import sdl_pkg::*;

  // the timer is eight bits; gaps must cover the device synchroniser
  if (HALF_CYC < 1 || HALF_CYC > 255 || PWRUP_CYC > 255 ||
      GAP_CYC < `SDL_SYNC_CYC || GAP_CYC < `SDL_TD_CYC ||
      GAP_CYC < `SDL_DLDAC_CYC || GAP_CYC > 255 ||
      LOAD_CYC < `SDL_WLDAC_CYC || LOAD_CYC < 2 || LOAD_CYC > 255 ||
      PWRUP_CYC < 1) begin : g_bad
    $error("sdl_master: parameter out of range");
  end

  // zero the bits below the valid length
  function automatic sdl_word_t pad_word(sdl_word_t w, sdl_cnt_t n);
    sdl_word_t m;
    m = 16'hFFFF;
    if (n != 5'h00 && n < 5'h10) begin
      m = 16'hFFFF << (5'h10 - n);
    end
    return w & m;
  endfunction

  sdl_mst_state_t st_q;
  logic [7:0] tmr_q;
  logic [3:0] bit_q;
  sdl_word_t sh_q;
  logic cs_n_q, sclk_q, sdi_q, ld_n_q, busy_q, done_q;

  // frame sequencer; every word is a full sixteen clocks
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= SDL_ST_PWR;
      tmr_q <= 8'(PWRUP_CYC - 1);
      bit_q <= 4'h0;
      sh_q <= 16'h0000;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      ld_n_q <= 1'b1;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      tmr_q <= (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
      case (st_q)
        SDL_ST_PWR: begin
          // no frame before the supply has settled
          if (tmr_q == 8'h00) begin
            st_q <= SDL_ST_IDLE;
            busy_q <= 1'b0;
            ld_n_q <= !LOAD_TIED;
          end
        end
        SDL_ST_IDLE: begin
          if (i_start) begin
            sh_q <= pad_word(i_word, i_len);
            sdi_q <= i_word[`SDL_WORD_W-1];
            cs_n_q <= 1'b0;
            bit_q <= 4'h0;
            busy_q <= 1'b1;
            tmr_q <= 8'(HALF_CYC - 1);
            st_q <= SDL_ST_LO;
          end
        end
        SDL_ST_LO: begin
          if (tmr_q == 8'h00) begin
            sclk_q <= 1'b1;
            tmr_q <= 8'(HALF_CYC - 1);
            st_q <= SDL_ST_HI;
          end
        end
        SDL_ST_HI: begin
          if (tmr_q == 8'h00) begin
            sclk_q <= 1'b0;
            tmr_q <= 8'(HALF_CYC - 1);
            if (bit_q == 4'hF) begin
              st_q <= SDL_ST_TAIL;
            end else begin
              // next bit changes on the falling edge
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[`SDL_WORD_W-2:0], 1'b0};
              sdi_q <= sh_q[`SDL_WORD_W-2];
              st_q <= SDL_ST_LO;
            end
          end
        end
        SDL_ST_TAIL: begin
          // one half period of lag, then close the frame
          if (tmr_q == 8'h00) begin
            cs_n_q <= 1'b1;
            tmr_q <= 8'(GAP_CYC - 1);
            st_q <= SDL_ST_GAP;
          end
        end
        SDL_ST_GAP: begin
          if (tmr_q == 8'h00) begin
            if (LOAD_TIED) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= SDL_ST_IDLE;
            end else begin
              // strobe only after select is high
              ld_n_q <= 1'b0;
              tmr_q <= 8'(LOAD_CYC - 1);
              st_q <= SDL_ST_LOAD;
            end
          end
        end
        SDL_ST_LOAD: begin
          if (tmr_q == 8'h00) begin
            ld_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= SDL_ST_IDLE;
          end
        end
        default: begin
          st_q <= SDL_ST_IDLE;
          cs_n_q <= 1'b1;
          sclk_q <= 1'b0;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.sclk = sclk_q;
  assign lnk.sdi = sdi_q;
  assign lnk.latch_load_n = ld_n_q;
endmodule

//--- tb/sdl_link_properties.sv
// link-side protocol checker for the serial word loader
`timescale 1ns/1ps
module sdl_link_properties #(
  parameter int PWRUP_CYC = 100   // power-up wait in clocks
) (
  input wire logic i_mclk,        // system clock
  input wire logic i_resetn,      // async reset, active low
  input wire logic cs_n,          // chip select, active low
  input wire logic sclk,          // link clock
  input wire logic sdi,           // serial data
  input wire logic latch_load_n   // load strobe, active low
);
  logic sclk_q;
  logic [4:0] rise_q;
  logic [15:0] up_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  // link clock one sample back, for rise detection
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  // rises inside the frame; saturates so a runaway frame cannot wrap
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) rise_q <= 5'h00;
    else if (cs_n) rise_q <= 5'h00;
    else if (sclk && !sclk_q && rise_q != 5'h1F) rise_q <= rise_q + 5'h01;
  end

  // clocks since reset release, saturating
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) up_q <= 16'h0000;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
  end

  a_data_on_fall: assert property (
    !cs_n && !$stable(sdi) |-> $fell(sclk) || $fell(cs_n))
    else $error("data moved off a falling edge");
  a_quiet_deselected: assert property (
    cs_n |-> !sclk)
    else $error("link clock high while deselected");
  a_sixteen_clocks: assert property (
    $rose(cs_n) |-> rise_q == 5'h10)
    else $error("frame without sixteen clocks");
  a_prompt_select: assert property (
    $fell(sclk) && rise_q == 5'h10 |-> ##[1:3] $rose(cs_n))
    else $error("select late after last clock");
  a_lead_time: assert property (
    $fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("clock rose with select fall");
  a_strobe_idle_frame: assert property (
    !cs_n |-> latch_load_n)
    else $error("strobe low inside frame");
  a_strobe_after_gap: assert property (
    $fell(latch_load_n) |-> cs_n && $past(cs_n, 3))
    else $error("strobe too soon after select");
  a_strobe_width: assert property (
    $fell(latch_load_n) |-> !latch_load_n [*3] ##1 latch_load_n)
    else $error("strobe width wrong");
  a_powerup_wait: assert property (
    !cs_n |-> int'(up_q) >= PWRUP_CYC)
    else $error("frame before power-up wait");

  c_frame_end: cover property ($rose(cs_n));
  c_strobe: cover property ($fell(latch_load_n));
  c_next_frame: cover property ($rose(cs_n) ##[3:20] $fell(cs_n));
endmodule

//--- tb/serial_dac_word_loader_tb_top.sv
// bench: master drives one converter, a bit-banged link drives another
`timescale 1ns/1ps
`include "sdl_map.svh"
module serial_dac_word_loader_tb_top;
  import sdl_pkg::*;
  localparam int PWR_CYC = `SDL_PWRUP_CYC;
  logic i_mclk, i_resetn, start, busy, done;
  logic loaded_a, upd_a, short_a, long_a, short_b, long_b;
  sdl_word_t word, in_a, lat_a, in_b, lat_b, lat_c;
  sdl_cnt_t len, bits_a, bits_b;
  sdl_seg_t seg_a;
  sdl_ladder_t lad_a;
  logic [15:0] n_load, n_upd;
  int failures, compares, t;
  sdl_word_t ws [5] = '{16'hA5C3, 16'hFFFF, 16'h8001, 16'h1234, 16'h0000};
  sdl_cnt_t ls [5] = '{5'h10, 5'h00, 5'h10, 5'h08, 5'h10};
  sdl_link_if lnk_a ();
  sdl_link_if lnk_b ();
  sdl_link_if lnk_c ();

  sdl_master #(.PWRUP_CYC(PWR_CYC)) i_sdl_master (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(start),
    .i_word(word), .i_len(len), .o_busy(busy), .o_done(done),
    .lnk(lnk_a.master));
  sdl_device #(.HAS_LOAD(1'b1)) i_sdl_device (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .lnk(lnk_a.device),
    .o_input_word(in_a), .o_latch_word(lat_a),
    .o_segment_switch_ctl(seg_a), .o_ladder_switch_ctl(lad_a),
    .o_word_loaded(loaded_a), .o_latch_updated(upd_a),
    .o_short_word(short_a), .o_long_word(long_a), .o_frame_bits(bits_a));
  // second converter faces the bench, which may break link rules
  sdl_device #(.HAS_LOAD(1'b1)) i_sdl_device_b (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .lnk(lnk_b.device),
    .o_input_word(in_b), .o_latch_word(lat_b),
    .o_segment_switch_ctl(), .o_ladder_switch_ctl(),
    .o_word_loaded(), .o_latch_updated(),
    .o_short_word(short_b), .o_long_word(long_b), .o_frame_bits(bits_b));
  // strobe-tied master runs in step with the first, feeding the
  // no-load variant, so both rarely used modes see real frames
  sdl_master #(.PWRUP_CYC(PWR_CYC), .LOAD_TIED(1'b1)) i_sdl_master_c (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(start),
    .i_word(word), .i_len(len), .o_busy(), .o_done(),
    .lnk(lnk_c.master));
  sdl_device #(.HAS_LOAD(1'b0)) i_sdl_device_c (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .lnk(lnk_c.device),
    .o_input_word(), .o_latch_word(lat_c),
    .o_segment_switch_ctl(), .o_ladder_switch_ctl(),
    .o_word_loaded(), .o_latch_updated(),
    .o_short_word(), .o_long_word(), .o_frame_bits());
  sdl_link_properties #(.PWRUP_CYC(PWR_CYC)) i_sdl_link_properties (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .cs_n(lnk_a.cs_n),
    .sclk(lnk_a.sclk), .sdi(lnk_a.sdi), .latch_load_n(lnk_a.latch_load_n));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // pulses seen on the master-driven converter
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      n_load <= 16'h0000;
      n_upd <= 16'h0000;
    end else begin
      if (loaded_a === 1'b1) n_load <= n_load + 16'h0001;
      if (upd_a === 1'b1) n_upd <= n_upd + 16'h0001;
    end
  end

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input sdl_word_t got, input sdl_word_t exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // segment k on when the nibble exceeds k
  function automatic sdl_word_t therm(input logic [3:0] nib);
    therm = 16'h0000;
    for (int k = 0; k < 15; k++) begin
      therm[k] = (nib > k);
    end
  endfunction

  // one word through the master; short lengths come back zero padded
  task automatic send_a(input int i);
    sdl_word_t prev;
    sdl_word_t exp;
    int n;
    int k;
    n = (ls[i] == 5'h00) ? 16 : int'(ls[i]);
    exp = ws[i] & ~(16'hFFFF >> n);
    prev = lat_a;
    word = ws[i];
    len = ls[i];
    start = 1'b1;
    @(posedge i_mclk) #1;
    start = 1'b0;
    for (k = 0; k < 200 && loaded_a !== 1'b1; k++) @(posedge i_mclk) #1;
    chk(in_a, exp);
    chk(lat_a, prev);
    chk(lat_c, exp);
    for (k = k; k < 300 && done !== 1'b1; k++) @(posedge i_mclk) #1;
    chk({15'h0000, done}, 16'h0001);
    repeat (4) @(posedge i_mclk) #1;
    chk(lat_a, exp);
    chk({1'b0, seg_a}, therm(exp[15:12]));
    chk({4'h0, lad_a}, {4'h0, exp[11:0]});
    chk({short_a, long_a, 9'h000, bits_a}, 16'h0010);
  endtask

  // bit-banged frame, 80 ns link clock; sel is the select level held
  task automatic frame_b(input logic [31:0] d, input int n, input logic sel);
    lnk_b.cs_n = sel;
    #40;
    for (int k = n - 1; k >= 0; k--) begin
      lnk_b.sdi = d[k];
      #40 lnk_b.sclk = 1'b1;
      #40 lnk_b.sclk = 1'b0;
    end
    // released data line must not keep looking valid
    lnk_b.sdi = ~lnk_b.sdi;
    #40 lnk_b.cs_n = 1'b1;
    repeat (6) @(posedge i_mclk) #1;
  endtask

  initial begin
    failures = 0;
    compares = 0;
    i_resetn = 1'b0;
    start = 1'b0;
    word = 16'h0000;
    len = 5'h00;
    lnk_b.cs_n = 1'b1;
    lnk_b.sclk = 1'b0;
    lnk_b.sdi = 1'b0;
    lnk_b.latch_load_n = 1'b0;
    repeat (10) @(posedge i_mclk) #1;
    i_resetn = 1'b1;
    chk(lat_a | in_a | {4'h0, lad_a} | {1'b0, seg_a}, 16'h0000);
    chk(in_b | lat_b | lat_c, 16'h0000);
    for (t = 0; t < 300 && busy !== 1'b0; t++) @(posedge i_mclk) #1;
    chk({15'h0000, busy}, 16'h0000);
    for (int i = 0; i < 5; i++) send_a(i);
    chk(n_load, 16'h0005);
    chk(n_upd, 16'h0005);
    frame_b(32'h3C5A, 16, 1'b0);
    chk(in_b, 16'h3C5A);
    chk(lat_b, 16'h3C5A);
    frame_b(32'hFF, 8, 1'b1);
    frame_b(32'h6, 4, 1'b0);
    chk(in_b, 16'hC5A6);
    chk({short_b, long_b, 9'h000, bits_b}, 16'h8004);
    frame_b(32'hF1234, 20, 1'b0);
    chk(in_b, 16'h1234);
    chk({short_b, long_b, 9'h000, bits_b}, 16'h4014);
    lnk_b.latch_load_n = 1'b1;
    frame_b(32'hBEEF, 16, 1'b0);
    chk(lat_b, 16'h1234);
    lnk_b.latch_load_n = 1'b0;
    repeat (3) @(posedge i_mclk) #1;
    lnk_b.latch_load_n = 1'b1;
    repeat (5) @(posedge i_mclk) #1;
    chk(lat_b, 16'hBEEF);
    chk(in_b, 16'hBEEF);
    stop_test();
  end

  // a hang counts as a failure
  initial begin
    #500000;
    failures++;
    stop_test();
  end
endmodule
